// [logic/rlx_regs.v]
// Read latency and extended status register block with serial command port
//
// Overview of operation
// - Four-bit dummy field: 1..15 is the exact count, 0 picks per-command default.
// - Default: fast read, single-line DDR, ID and info reads use 8, quad mode 6.
// - Default: dual and quad output reads use 8; single-wire mode only.
// - Default: dual I/O read and its DDR form use 4; single-wire mode only.
// - Default: quad I/O read and its DDR form use 6 in both modes.
// - Dual I/O DDR read is refused in quad command mode.
// - Bits 7..5 are drive strength, read/write, both copies, default all ones.
// - Opcode 85h writes the persistent copy, 83h the working copy.
// - Bits 3..0 are read-only; written data for them is dropped.
// - Bit 0 mirrors the busy flag of the status register.
// - Bit 1 is set on an erase or program protection violation.
// - Bit 2 is set when a program fails or is refused.
// - Bit 3 is set when an erase fails or is refused.
// - Bit 4 enables the training pattern, read/write, both copies, default 0.
// - After power-up the working copies load from the persistent copies.
// - Error flags stick until clear command or reset; commands still run.
`timescale 1ns/10ps
`include "rlx_defs.vh"
module rlx_regs #(
	parameter [7:0] RD_EXT_OP  = 8'h81,
	parameter [7:0] RD_RD_OP   = 8'h61,
	parameter [7:0] CLR_OP     = 8'h82,
	parameter [7:0] UID_OP     = 8'h4b,
	parameter [7:0] INFO_OP    = 8'h68
) (
	// Clock and resets
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       por_n_in,
	// Serial bus pins
	input  wire       sck_in,
	input  wire       cs_n_in,
	input  wire [3:0] io_in,
	output reg  [3:0] io_out,
	output reg  [3:0] io_oe_out,
	// Device state and events
	input  wire       quad_command_mode_in,
	input  wire       write_in_progress_in,
	input  wire       protect_violation_set_in,
	input  wire       program_error_set_in,
	input  wire       erase_error_set_in,
	input  wire       sw_reset_in,
	// Read setup for the array read path
	output reg        read_start_out,
	output reg  [7:0] read_opcode_out,
	output reg  [3:0] dummy_cycles_out,
	output reg        cmd_reject_out,
	// Working configuration and status
	output reg  [2:0] drive_strength_out,
	output reg        training_pattern_enable_out,
	output reg  [7:0] ext_params_out
);

	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_OPCODE = 3'd1;
	localparam [2:0] ST_WDATA  = 3'd2;
	localparam [2:0] ST_TX     = 3'd3;
	localparam [2:0] ST_SKIP   = 3'd4;

	// True for any read whose latency this block sets
	function is_read;
		input [7:0] op;
		begin
			case (op)
				`RLX_OP_FAST_A, `RLX_OP_FAST_B, `RLX_OP_SDDR_A, `RLX_OP_SDDR_B,
				`RLX_OP_DOUT_A, `RLX_OP_DOUT_B, `RLX_OP_QOUT_A, `RLX_OP_QOUT_B,
				`RLX_OP_DIO_A, `RLX_OP_DIO_B, `RLX_OP_DDDR_A, `RLX_OP_DDDR_B,
				`RLX_OP_QIO_A, `RLX_OP_QIO_B, `RLX_OP_QDDR_A, `RLX_OP_QDDR_B,
				UID_OP, INFO_OP:
					is_read = 1'b1;
				default:
					is_read = 1'b0;
			endcase
		end
	endfunction

	// Reads that exist only in single-wire command mode
	function spi_only;
		input [7:0] op;
		begin
			case (op)
				`RLX_OP_DOUT_A, `RLX_OP_DOUT_B, `RLX_OP_QOUT_A, `RLX_OP_QOUT_B: spi_only = 1'b1;
				`RLX_OP_DIO_A, `RLX_OP_DIO_B: spi_only = 1'b1;
				`RLX_OP_DDDR_A, `RLX_OP_DDDR_B: spi_only = 1'b1;
				default: spi_only = 1'b0;
			endcase
		end
	endfunction

	// Dummy count for a read: field value, or the per-command default
	function [3:0] dummy_for;
		input [7:0] op;
		input       quad;
		input [3:0] field;
		begin
			if (field != 4'd0) begin
				dummy_for = field;
			end else begin
				case (op)
					`RLX_OP_DOUT_A, `RLX_OP_DOUT_B, `RLX_OP_QOUT_A, `RLX_OP_QOUT_B:
						dummy_for = `RLX_DFLT_OUT;
					`RLX_OP_DIO_A, `RLX_OP_DIO_B, `RLX_OP_DDDR_A, `RLX_OP_DDDR_B:
						dummy_for = `RLX_DFLT_DUAL_IO;
					`RLX_OP_QIO_A, `RLX_OP_QIO_B, `RLX_OP_QDDR_A, `RLX_OP_QDDR_B:
						dummy_for = `RLX_DFLT_QUAD_IO;
					default:
						dummy_for = quad ? `RLX_DFLT_FAST_QUAD : `RLX_DFLT_FAST_SPI;
				endcase
			end
		end
	endfunction

	wire [5:0] pins_q;
	wire [7:0] nv_rd;
	wire [7:0] nv_ext;
	wire       cs_s;
	wire       sck_s;
	wire [3:0] io_s;

	reg        sck_prev_reg;
	reg        cs_prev_reg;
	reg  [2:0] state_reg;
	reg  [7:0] rx_sr_reg;
	reg  [3:0] bit_cnt_reg;
	reg  [7:0] op_reg;
	reg  [7:0] stage_reg;
	reg        stage_ok_reg;
	reg  [7:0] tx_sr_reg;
	reg  [3:0] tx_cnt_reg;
	reg        tx_ext_reg;
	reg  [7:0] vol_rd_reg;
	reg  [3:0] vol_ext_hi_reg;
	reg        load_pend_reg;
	reg        prot_err_reg;
	reg        prog_err_reg;
	reg        erase_err_reg;
	reg        clr_cmd_reg;
	reg        nv_wr_rd_reg;
	reg        nv_wr_ext_reg;

	// Pin synchroniser; chip select idles high
	rlx_sync #(
		.WIDTH   (6),
		.RST_VAL (6'h20)
	) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({cs_n_in, sck_in, io_in}),
		.q_out    (pins_q)
	);

	// Persistent register copies
	rlx_nv_store u_nv (
		.clk_in        (clk_in),
		.por_n_in      (por_n_in),
		.wr_rd_in      (nv_wr_rd_reg),
		.wr_ext_in     (nv_wr_ext_reg),
		.wdata_in      (stage_reg),
		.rd_param_out  (nv_rd),
		.ext_param_out (nv_ext)
	);

	assign cs_s  = pins_q[5];
	assign sck_s = pins_q[4];
	assign io_s  = pins_q[3:0];

	// Edge detection and byte assembly
	wire       sck_rise  = sck_s & ~sck_prev_reg;
	wire       sck_fall  = ~sck_s & sck_prev_reg;
	wire       cs_fall   = ~cs_s & cs_prev_reg;
	wire       quad      = quad_command_mode_in;
	wire [3:0] step      = quad ? 4'd4 : 4'd1;
	wire [3:0] cnt_add   = bit_cnt_reg + step;
	wire [7:0] rx_shift  = quad ? {rx_sr_reg[3:0], io_s} : {rx_sr_reg[6:0], io_s[0]};
	wire       byte_done = sck_rise && (cnt_add == 4'd8);
	// Status bits come from live state, never from written data
	wire [7:0] ext_view  = {vol_ext_hi_reg, erase_err_reg, prog_err_reg, prot_err_reg,
		write_in_progress_in};
	wire [7:0] tx_value  = tx_ext_reg ? ext_view : vol_rd_reg;
	wire       err_clr   = clr_cmd_reg | sw_reset_in;

	// Serial command engine
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sck_prev_reg    <= 1'b0;
			cs_prev_reg     <= 1'b1;
			state_reg       <= ST_IDLE;
			rx_sr_reg       <= 8'h00;
			bit_cnt_reg     <= 4'h0;
			op_reg          <= 8'h00;
			stage_reg       <= 8'h00;
			stage_ok_reg    <= 1'b0;
			tx_sr_reg       <= 8'h00;
			tx_cnt_reg      <= 4'h0;
			tx_ext_reg      <= 1'b0;
			io_out          <= 4'h0;
			io_oe_out       <= 4'h0;
			read_start_out  <= 1'b0;
			read_opcode_out <= 8'h00;
			dummy_cycles_out <= 4'h0;
			cmd_reject_out  <= 1'b0;
			clr_cmd_reg     <= 1'b0;
			nv_wr_rd_reg    <= 1'b0;
			nv_wr_ext_reg   <= 1'b0;
		end else begin
			sck_prev_reg   <= sck_s;
			cs_prev_reg    <= cs_s;
			read_start_out <= 1'b0;
			cmd_reject_out <= 1'b0;
			clr_cmd_reg    <= 1'b0;
			nv_wr_rd_reg   <= 1'b0;
			nv_wr_ext_reg  <= 1'b0;
			if (cs_s) begin
				// Deselect ends the command; a staged write commits here
				state_reg    <= ST_IDLE;
				io_oe_out    <= 4'h0;
				stage_ok_reg <= 1'b0;
				if (stage_ok_reg) begin
					case (op_reg)
						`RLX_OP_SET_EXT_NV: nv_wr_ext_reg <= 1'b1;
						`RLX_OP_SET_RD_NV:  nv_wr_rd_reg <= 1'b1;
						default:            nv_wr_rd_reg <= 1'b0;
					endcase
				end
			end else if (cs_fall) begin
				state_reg   <= ST_OPCODE;
				bit_cnt_reg <= 4'h0;
			end else begin
				if (sck_rise) begin
					rx_sr_reg   <= rx_shift;
					bit_cnt_reg <= byte_done ? 4'h0 : cnt_add;
				end
				case (state_reg)
					ST_OPCODE: begin
						if (byte_done) begin
							op_reg <= rx_shift;
							if (rx_shift == `RLX_OP_SET_EXT_NV || rx_shift == `RLX_OP_SET_EXT_V ||
								rx_shift == `RLX_OP_SET_RD_NV || rx_shift == `RLX_OP_SET_RD_V_A ||
								rx_shift == `RLX_OP_SET_RD_V_B) begin
								state_reg <= ST_WDATA;
							end else if (rx_shift == RD_EXT_OP || rx_shift == RD_RD_OP) begin
								tx_ext_reg <= (rx_shift == RD_EXT_OP);
								tx_sr_reg  <= (rx_shift == RD_EXT_OP) ? ext_view : vol_rd_reg;
								tx_cnt_reg <= 4'h0;
								state_reg  <= ST_TX;
							end else if (is_read(rx_shift) && quad && spi_only(rx_shift)) begin
								cmd_reject_out <= 1'b1;
								state_reg      <= ST_SKIP;
							end else if (is_read(rx_shift)) begin
								// Latency is sampled per command from the working copy
								read_start_out   <= 1'b1;
								read_opcode_out  <= rx_shift;
								dummy_cycles_out <= dummy_for(rx_shift, quad,
									vol_rd_reg[`RLX_DUMMY_MSB:`RLX_DUMMY_LSB]);
								state_reg        <= ST_SKIP;
							end else begin
								clr_cmd_reg <= (rx_shift == CLR_OP);
								state_reg   <= ST_SKIP;
							end
						end
					end
					ST_WDATA: begin
						if (byte_done) begin
							stage_reg    <= rx_shift;
							stage_ok_reg <= 1'b1;
							state_reg    <= ST_SKIP;
						end
					end
					ST_TX: begin
						// Shift out MSB first, repeating the register
						if (sck_fall) begin
							io_out    <= quad ? tx_sr_reg[7:4] : {2'b00, tx_sr_reg[7], 1'b0};
							io_oe_out <= quad ? 4'hf : 4'h2;
							if (tx_cnt_reg + step == 4'd8) begin
								tx_cnt_reg <= 4'h0;
								tx_sr_reg  <= tx_value;
							end else begin
								tx_cnt_reg <= tx_cnt_reg + step;
								tx_sr_reg  <= quad ? {tx_sr_reg[3:0], 4'h0} : {tx_sr_reg[6:0], 1'b0};
							end
						end
					end
					ST_SKIP: state_reg <= ST_SKIP;
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Working copies: loaded from persistent copies after reset
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			vol_rd_reg     <= `RLX_RD_RESET;
			vol_ext_hi_reg <= `RLX_EXT_HI_RESET;
			load_pend_reg  <= 1'b1;
		end else if (load_pend_reg) begin
			vol_rd_reg     <= nv_rd;
			vol_ext_hi_reg <= nv_ext[7:4];
			load_pend_reg  <= 1'b0;
		end else if (cs_s && stage_ok_reg) begin
			if (op_reg == `RLX_OP_SET_EXT_V)
				vol_ext_hi_reg <= stage_reg[7:4];
			if (op_reg == `RLX_OP_SET_RD_V_A || op_reg == `RLX_OP_SET_RD_V_B)
				vol_rd_reg <= stage_reg;
		end
	end

	// Sticky error flags; a set in the clear cycle wins
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			prot_err_reg  <= 1'b0;
			prog_err_reg  <= 1'b0;
			erase_err_reg <= 1'b0;
		end else begin
			prot_err_reg  <= (prot_err_reg & ~err_clr) | protect_violation_set_in;
			prog_err_reg  <= (prog_err_reg & ~err_clr) | program_error_set_in;
			erase_err_reg <= (erase_err_reg & ~err_clr) | erase_error_set_in;
		end
	end

	// Registered configuration and status outputs
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			drive_strength_out          <= 3'h7;
			training_pattern_enable_out <= 1'b0;
			ext_params_out              <= `RLX_EXT_RESET;
		end else begin
			drive_strength_out          <= vol_ext_hi_reg[3:1];
			training_pattern_enable_out <= vol_ext_hi_reg[0];
			ext_params_out              <= ext_view;
		end
	end

endmodule

// [common/rlx_defs.vh]
// Constants for the read-latency and extended-status register block
`ifndef RLX_DEFS_VH
`define RLX_DEFS_VH

// Register-set opcodes
`define RLX_OP_SET_EXT_NV   8'h85
`define RLX_OP_SET_EXT_V    8'h83
`define RLX_OP_SET_RD_NV    8'h65
`define RLX_OP_SET_RD_V_A   8'hc0
`define RLX_OP_SET_RD_V_B   8'h63

// Fast read opcode families
`define RLX_OP_FAST_A       8'h0b
`define RLX_OP_FAST_B       8'h0c
`define RLX_OP_SDDR_A       8'h0d
`define RLX_OP_SDDR_B       8'h0e
`define RLX_OP_DOUT_A       8'h3b
`define RLX_OP_DOUT_B       8'h3c
`define RLX_OP_QOUT_A       8'h6b
`define RLX_OP_QOUT_B       8'h6c
`define RLX_OP_DIO_A        8'hbb
`define RLX_OP_DIO_B        8'hbc
`define RLX_OP_DDDR_A       8'hbd
`define RLX_OP_DDDR_B       8'hbe
`define RLX_OP_QIO_A        8'heb
`define RLX_OP_QIO_B        8'hec
`define RLX_OP_QDDR_A       8'hed
`define RLX_OP_QDDR_B       8'hee

// Reset values
`define RLX_RD_RESET        8'h00
`define RLX_EXT_RESET       8'he0
`define RLX_EXT_HI_RESET    4'he

// Field positions
`define RLX_DUMMY_MSB       6
`define RLX_DUMMY_LSB       3
`define RLX_ODS_MSB         7
`define RLX_ODS_LSB         5
`define RLX_TRAIN_BIT       4
`define RLX_EERR_BIT        3
`define RLX_PERR_BIT        2
`define RLX_PROT_BIT        1
`define RLX_WIP_BIT         0

// Default dummy counts
`define RLX_DFLT_FAST_SPI   4'd8
`define RLX_DFLT_FAST_QUAD  4'd6
`define RLX_DFLT_OUT        4'd8
`define RLX_DFLT_DUAL_IO    4'd4
`define RLX_DFLT_QUAD_IO    4'd6

`endif

// [logic/rlx_sync.v]
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module rlx_sync #(
	parameter WIDTH               = 6,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input  wire             clk_in,
	input  wire             rst_n_in,
	// Pins in, filtered levels out
	input  wire [WIDTH-1:0] d_in,
	output reg  [WIDTH-1:0] q_out
);

	reg [WIDTH-1:0] s1_reg;
	reg [WIDTH-1:0] s2_reg;
	reg [WIDTH-1:0] s3_reg;

	// Stage chain; output takes a bit once stages two and three agree
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q_out  <= RST_VAL;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_out  <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q_out & (s2_reg ^ s3_reg));
		end
	end

endmodule

// [logic/rlx_nv_store.v]
// Persistent copies of the read and extended read registers
`timescale 1ns/10ps
`include "rlx_defs.vh"
module rlx_nv_store (
	// Clock and power-on reset
	input  wire       clk_in,
	input  wire       por_n_in,
	// Write strobes and data
	input  wire       wr_rd_in,
	input  wire       wr_ext_in,
	input  wire [7:0] wdata_in,
	// Stored values
	output reg  [7:0] rd_param_out,
	output reg  [7:0] ext_param_out
);

	// Factory values at power-on, only writable bits kept
	always @(posedge clk_in) begin
		if (!por_n_in) begin
			rd_param_out  <= `RLX_RD_RESET;
			ext_param_out <= `RLX_EXT_RESET;
		end else begin
			if (wr_rd_in)
				rd_param_out <= wdata_in;
			if (wr_ext_in)
				ext_param_out <= {wdata_in[7:4], 4'h0};
		end
	end

endmodule

// [verif/rlx_regs_properties.sv]
// Port-level assertions for the read latency and extended status block
`timescale 1ns/10ps
module rlx_regs_properties (
	// Clock and reset
	input wire       clk_in,
	input wire       rst_n_in,
	// Observed inputs
	input wire       cs_n_in,
	input wire       quad_command_mode_in,
	input wire       write_in_progress_in,
	input wire       protect_violation_set_in,
	input wire       program_error_set_in,
	input wire       erase_error_set_in,
	input wire       sw_reset_in,
	// Observed outputs
	input wire       read_start_out,
	input wire       cmd_reject_out,
	input wire [3:0] dummy_cycles_out,
	input wire [2:0] drive_strength_out,
	input wire       training_pattern_enable_out,
	input wire [7:0] ext_params_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Bus idle with no software reset
	sequence s_quiet;
		(cs_n_in && !sw_reset_in)[*8];
	endsequence
	a_wip_rise: assert property ($rose(write_in_progress_in) |-> ##[1:3] ext_params_out[0])
		else $error("busy mirror did not set");
	a_wip_fall: assert property ($fell(write_in_progress_in) |-> ##[1:3] !ext_params_out[0])
		else $error("busy mirror did not clear");
	a_prot_set: assert property (protect_violation_set_in |-> ##[1:3] ext_params_out[1])
		else $error("protection flag not set");
	a_perr_set: assert property (program_error_set_in |-> ##[1:3] ext_params_out[2])
		else $error("program error flag not set");
	a_eerr_set: assert property (erase_error_set_in |-> ##[1:3] ext_params_out[3])
		else $error("erase error flag not set");
	a_flags_sticky: assert property (s_quiet |-> ($past(ext_params_out[3:1]) & ~ext_params_out[3:1]) == 3'h0)
		else $error("error flag dropped while idle");
	a_reject_quad: assert property (cmd_reject_out |-> quad_command_mode_in)
		else $error("refusal outside quad mode");
	a_start_single: assert property (read_start_out |-> !cmd_reject_out ##1 !read_start_out)
		else $error("read start not a lone pulse");
	a_dummy_nonzero: assert property (read_start_out |-> dummy_cycles_out != 4'h0)
		else $error("zero dummy count issued");
	a_cfg_at_idle: assert property ($changed({drive_strength_out, training_pattern_enable_out}) |-> cs_n_in)
		else $error("working config changed mid command");
	a_view_match: assert property (ext_params_out[7:4] == {drive_strength_out, training_pattern_enable_out})
		else $error("register view disagrees with outputs");
endmodule
bind rlx_regs rlx_regs_properties u_props (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
	.quad_command_mode_in(quad_command_mode_in), .write_in_progress_in(write_in_progress_in),
	.protect_violation_set_in(protect_violation_set_in), .program_error_set_in(program_error_set_in),
	.erase_error_set_in(erase_error_set_in), .sw_reset_in(sw_reset_in),
	.read_start_out(read_start_out), .cmd_reject_out(cmd_reject_out),
	.dummy_cycles_out(dummy_cycles_out), .drive_strength_out(drive_strength_out),
	.training_pattern_enable_out(training_pattern_enable_out), .ext_params_out(ext_params_out)
);

// [verif/rlx_host_model.sv]
// Host serial controller model, mode 0, most significant bit first
`timescale 1ns/10ps
module rlx_host_model (
	// Pins toward the device
	output logic       sck_out,
	output logic       cs_n_out,
	output logic [3:0] io_drv_out,
	input  wire  [3:0] io_pin_in
);
	// Clock stands still low between frames
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		io_drv_out = 4'h5;
	end
	// One slot of 80 ns: drive, rise, sample late in the high phase, fall
	task automatic slot(input logic [3:0] v, input logic q, inout logic [7:0] r);
		io_drv_out = q ? v : {~io_drv_out[3:1], v[0]};
		#40 sck_out = 1'b1;
		#40 r = {r[6:0], io_pin_in[1]};
		sck_out = 1'b0;
	endtask
	// Opcode, then a data byte (mode 1) or a byte of readback slots, eight in single-wire mode, two in quad (mode 2)
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int mode,
		input logic q, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		cs_n_out = 1'b0;
		#40;
		for (i = 0; i < (q ? 2 : 8); i++)
			slot(q ? op[7-4*i -: 4] : {3'h0, op[7-i]}, q, rd);
		for (i = 0; mode != 0 && i < (q ? 2 : 8); i++)
			slot(q ? dat[7-4*i -: 4] : {3'h0, dat[7-i]}, q, rd);
		#40 cs_n_out = 1'b1;
		io_drv_out = ~io_drv_out; // Released lines show no stale value
		#120;
	endtask
endmodule

// [verif/rlx_regs_tb_top.sv]
// Self-checking bench for the read latency and extended status block
`timescale 1ns/10ps
`include "rlx_defs.vh"
module rlx_regs_tb_top;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        por_n_in = 1'b0;
	logic        quad = 1'b0;
	logic        write_in_progress = 1'b0;
	logic [2:0]  err_set = 3'h0;
	logic        sw_rst = 1'b0;
	wire         sck, cs_n, start, reject, train;
	wire  [3:0]  host_io, io_out, io_oe, io_w, dummy;
	wire  [7:0]  ext, opc;
	wire  [2:0]  ods;
	logic        got_start = 1'b0;
	logic        got_rej = 1'b0;
	logic [3:0]  got_dummy = 4'h0;
	logic [7:0]  got_op = 8'h00;
	logic [7:0]  rd;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          i;
	// Quad flag, expected dummy count (0 means refused), opcode
	logic [15:0] rows [0:35] = '{16'h080b, 16'h080c, 16'h080d, 16'h080e, 16'h084b, 16'h0868,
		16'h083b, 16'h083c, 16'h086b, 16'h086c, 16'h04bb, 16'h04bc, 16'h04bd, 16'h04be,
		16'h06eb, 16'h06ec, 16'h06ed, 16'h06ee, 16'h160b, 16'h160c, 16'h160d, 16'h160e,
		16'h164b, 16'h1668, 16'h16eb, 16'h16ec, 16'h16ed, 16'h16ee, 16'h10bd, 16'h10be,
		16'h10bb, 16'h10bc, 16'h103b, 16'h103c, 16'h106b, 16'h106c};

	always #4 clk_in = ~clk_in;
	// Wire level: device where enabled, host elsewhere
	assign io_w = (io_oe & io_out) | (~io_oe & host_io);

	rlx_regs u_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
		.sck_in(sck), .cs_n_in(cs_n), .io_in(io_w), .io_out(io_out), .io_oe_out(io_oe),
		.quad_command_mode_in(quad), .write_in_progress_in(write_in_progress),
		.protect_violation_set_in(err_set[0]), .program_error_set_in(err_set[1]),
		.erase_error_set_in(err_set[2]), .sw_reset_in(sw_rst),
		.read_start_out(start), .read_opcode_out(opc), .dummy_cycles_out(dummy),
		.cmd_reject_out(reject), .drive_strength_out(ods),
		.training_pattern_enable_out(train), .ext_params_out(ext)
	);
	rlx_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .io_drv_out(host_io), .io_pin_in(io_w));

	// Catch one-cycle pulses of the read path; cut a hang short
	always @(posedge clk_in) begin
		cyc++;
		if (start) begin
			got_start <= 1'b1;
			got_dummy <= dummy;
			got_op    <= opc;
		end
		if (reject)
			got_rej <= 1'b1;
		if (cyc == 40000) begin
			failures++;
			tally_and_finish;
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int mode);
		@(posedge clk_in) #1;
		got_start = 1'b0;
		got_rej = 1'b0;
		u_host.frame(op, dat, mode, quad, rd);
	endtask

	task automatic rd_case(input logic [15:0] r);
		quad = r[12];
		cmd(r[7:0], 8'h00, 0);
		chk("start", {7'h0, r[11:8] != 4'h0}, {7'h0, got_start});
		chk("reject", {7'h0, r[11:8] == 4'h0}, {7'h0, got_rej});
		if (r[11:8] != 4'h0) begin
			chk("dummy", {4'h0, r[11:8]}, {4'h0, got_dummy});
			chk("opcode", r[7:0], got_op);
		end
		quad = 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic tally_and_finish;
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		settle(16);
		rst_n_in = 1'b1;
		por_n_in = 1'b1;
		settle(6);
		chk("ext", 8'he0, ext);
		chk("ods", 8'h07, {5'h0, ods});
		for (i = 0; i < 36; i++)
			rd_case(rows[i]);
		// Nonzero field overrides defaults from the next command on
		cmd(`RLX_OP_SET_RD_V_B, 8'h78, 1);
		rd_case(16'h1f0b);
		cmd(`RLX_OP_SET_RD_V_A, 8'h08, 1);
		rd_case(16'h01bb);
		// Working copy write, low nibble dropped
		cmd(`RLX_OP_SET_EXT_V, 8'h5f, 1);
		chk("ext", 8'h50, ext);
		chk("train", 8'h01, {7'h0, train});
		cmd(8'h81, 8'h00, 2);
		chk("readback", 8'h50, rd);
		// Persistent write shows only after the reload at reset
		cmd(`RLX_OP_SET_EXT_NV, 8'h3f, 1);
		chk("ext", 8'h50, ext);
		cmd(`RLX_OP_SET_RD_NV, 8'h50, 1);
		cmd(8'h61, 8'h00, 2);
		chk("readback", 8'h08, rd);
		rst_n_in = 1'b0;
		settle(4);
		rst_n_in = 1'b1;
		settle(6);
		chk("ext", 8'h30, ext);
		chk("ods", 8'h01, {5'h0, ods});
		cmd(8'h61, 8'h00, 2);
		chk("readback", 8'h50, rd);
		rd_case(16'h0a0b);
		// Status bits, stickiness and commands running while flagged
		write_in_progress = 1'b1;
		err_set = 3'h7;
		settle(1);
		err_set = 3'h0;
		settle(4);
		chk("ext", 8'h3f, ext);
		cmd(8'h81, 8'h00, 2);
		chk("readback", 8'h3f, rd);
		write_in_progress = 1'b0;
		cmd(`RLX_OP_FAST_A, 8'h00, 0);
		chk("ext", 8'h3e, ext);
		chk("start", 8'h01, {7'h0, got_start});
		cmd(8'h82, 8'h00, 0);
		chk("ext", 8'h30, ext);
		for (i = 0; i < 3; i++) begin
			err_set = 3'h1 << i;
			settle(1);
			err_set = 3'h0;
			settle(4);
			chk("ext", 8'h30 | (8'h02 << i), ext);
			sw_rst = 1'b1;
			settle(1);
			sw_rst = 1'b0;
			settle(4);
			chk("ext", 8'h30, ext);
		end
		tally_and_finish;
	end
endmodule
